// >>> core/mtr_regbank.sv
// indirectly addressed register bank of the metering core
// Functional notes
// - address 0x01 reads 24-bit signed active total, no clear, resets zero
// - address 0x02 reads active total then clears it
// - address 0x03 holds active energy over programmed half line cycles
// - address 0x12 holds 16-bit half-cycle count, resets 0xffff
// - reactive totals at 0x04, 0x05, 0x06 in same three forms
// - apparent totals at 0x07-0x09; rms select bit accumulates current rms
// - address 0x0a reads line period or frequency per config_two
// - config_one at 0x0b resets 0x06, config_two at 0x0c resets 0x40
// - waveform select 0x0d and no-load threshold 0x0e reset zero
// - accumulation config at 0x0f, read/write, resets zero
// - signed phase calibration at 0x10 resets 0x40
// - 12-bit zero-crossing timeout at 0x11 resets 0xfff
// - sag cycle count at 0x13 resets 0xff
// - 16-bit sag level at 0x14 resets zero
// - peak thresholds current 0x15, voltage 0x16, reset 0xffff
// - current peak read at 0x17 plain, at 0x18 read then clear
// - voltage peak read at 0x19 plain, at 0x1a read then clear
// - amplifier gain at 0x1b, read/write, resets zero
// - pointer byte holds 7-bit address, top bit set means write
// - one-byte register write copies low data byte only
// - one-byte register read loads low byte, zeroes middle and high
`timescale 1ns/1ps
`default_nettype none
module mtr_regbank #(
  parameter bit HAS_REACTIVE = 1'b1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // processor side pointer and data bytes
  input wire logic ptrWrEn,
  input wire logic [7:0] ptrWrData,
  input wire logic [2:0] dataWrEn,
  input wire logic [7:0] dataWrData,
  output logic [7:0] ptrByte,
  output logic [7:0] dataLow,
  output logic [7:0] dataMid,
  output logic [7:0] dataHigh,
  // metering datapath inputs
  input wire logic activeValid,
  input wire logic [mtr_pkg::ENERGY_W-1:0] activeDelta,
  input wire logic reactiveValid,
  input wire logic [mtr_pkg::ENERGY_W-1:0] reactiveDelta,
  input wire logic apparentValid,
  input wire logic [mtr_pkg::ENERGY_W-1:0] apparentDelta,
  input wire logic irmsValid,
  input wire logic [mtr_pkg::ENERGY_W-1:0] irmsDelta,
  input wire logic halfCycle,
  input wire logic [15:0] periodVal,
  input wire logic [15:0] freqVal,
  input wire logic sampleValid,
  input wire logic [mtr_pkg::PEAK_W-1:0] currentSample,
  input wire logic [mtr_pkg::PEAK_W-1:0] voltageSample,
  // settings to the metering datapath
  output logic [7:0] configOne,
  output logic [7:0] configTwo,
  output logic [7:0] waveformSelect,
  output logic [7:0] noLoadThreshold,
  output logic [7:0] accumulationConfig,
  output logic [7:0] phaseCalibration,
  output logic [11:0] zeroCrossTimeout,
  output logic [7:0] sagCycleCount,
  output logic [15:0] sagLevel,
  output logic [7:0] pgaGain,
  // events
  output logic lineCycleDone,
  output logic currentPeakEvent,
  output logic voltagePeakEvent
);
  import mtr_pkg::*;

  // ************************************************
  // declarations
  // ************************************************
  logic [7:0] ptr_r, ptr_nxt;
  logic [7:0] dLow_r, dLow_nxt, dMid_r, dMid_nxt, dHigh_r, dHigh_nxt;
  logic [7:0] cfg1_r, cfg1_nxt, cfg2_r, cfg2_nxt, wave_r, wave_nxt;
  logic [7:0] noLoad_r, noLoad_nxt, accCfg_r, accCfg_nxt, phase_calibration_r, phase_calibration_nxt;
  logic [11:0] zero_cross_timeout_r, zero_cross_timeout_nxt;
  logic [15:0] lineCnt_r, lineCnt_nxt;
  logic [7:0] sag_cycle_count_r, sag_cycle_count_nxt;
  logic [15:0] sag_level_r, sag_level_nxt, iThr_r, iThr_nxt, vThr_r, vThr_nxt;
  logic [7:0] gain_r, gain_nxt;
  logic [HALF_W-1:0] halfCnt_r, halfCnt_nxt;
  logic [PEAK_W-1:0] current_peak_r, current_peak_nxt, voltage_peak_r, voltage_peak_nxt;
  logic lineEnd_r, lineEnd_nxt;
  logic iEvt_r, iEvt_nxt, vEvt_r, vEvt_nxt;
  logic access, isWrite, isRead;
  logic [6:0] addr;
  logic [2:0] rdLen;
  logic [23:0] rdVal;
  logic lineEnd;
  logic clrActive, clrReactive, clrApparent, clrIPeak, clrVPeak;
  logic [ENERGY_W-1:0] actTot, actLine, reTot, reLine, apTot, apLine;
  logic apValid;
  logic [ENERGY_W-1:0] apDelta;
  logic reValid;

  // ************************************************
  // pointer decode
  // ************************************************
  always_comb begin
    access = ptrWrEn;
    isWrite = access & ptrWrData[PTR_WR_BIT];
    isRead = access & ~ptrWrData[PTR_WR_BIT];
    addr = ptrWrData[ADDR_W-1:0];
  end

  // ************************************************
  // energy accumulators
  // ************************************************
  always_comb begin
    clrActive = isRead && (addr == ADDR_ACTIVE_ACC_CLR);
    clrReactive = isRead && (addr == ADDR_REACTIVE_ACC_CLR);
    clrApparent = isRead && (addr == ADDR_APPARENT_ACC_CLR);
    clrIPeak = isRead && (addr == ADDR_CURRENT_PEAK_CLR);
    clrVPeak = isRead && (addr == ADDR_VOLTAGE_PEAK_CLR);
    apValid = cfg2_r[CFG2_RMS_SEL_BIT] ? irmsValid : apparentValid;
    apDelta = cfg2_r[CFG2_RMS_SEL_BIT] ? irmsDelta : apparentDelta;
    reValid = HAS_REACTIVE & reactiveValid;
  end

  mtr_energy_chan #(.W(ENERGY_W)) activeChan (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .addEn(activeValid),
    .delta(activeDelta),
    .clrReq(clrActive),
    .lineEnd(lineEnd),
    .total(actTot),
    .lineTotal(actLine)
  );

  mtr_energy_chan #(.W(ENERGY_W)) reactiveChan (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .addEn(reValid),
    .delta(reactiveDelta),
    .clrReq(clrReactive),
    .lineEnd(lineEnd),
    .total(reTot),
    .lineTotal(reLine)
  );

  mtr_energy_chan #(.W(ENERGY_W)) apparentChan (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .addEn(apValid),
    .delta(apDelta),
    .clrReq(clrApparent),
    .lineEnd(lineEnd),
    .total(apTot),
    .lineTotal(apLine)
  );

  // ************************************************
  // line cycle counting and peak capture
  // ************************************************
  always_comb begin
    lineEnd = halfCycle && ((halfCnt_r + 16'h0001) >= lineCnt_r);
    if (lineEnd) begin
      halfCnt_nxt = RST_HALF_ZERO;
    end else if (halfCycle) begin
      halfCnt_nxt = halfCnt_r + 16'h0001;
    end else begin
      halfCnt_nxt = halfCnt_r;
    end
    lineEnd_nxt = lineEnd;
    current_peak_nxt = clrIPeak ? '0 : current_peak_r;
    if (sampleValid && (currentSample > current_peak_nxt)) begin
      current_peak_nxt = currentSample;
    end
    voltage_peak_nxt = clrVPeak ? '0 : voltage_peak_r;
    if (sampleValid && (voltageSample > voltage_peak_nxt)) begin
      voltage_peak_nxt = voltageSample;
    end
    iEvt_nxt = sampleValid && (currentSample[PEAK_W-1:THR_LSB] > iThr_r);
    vEvt_nxt = sampleValid && (voltageSample[PEAK_W-1:THR_LSB] > vThr_r);
  end

  // ************************************************
  // read multiplexer
  // ************************************************
  always_comb begin
    rdVal = 24'h000000;
    rdLen = 3'h1;
    case (addr)
      ADDR_ACTIVE_ACC, ADDR_ACTIVE_ACC_CLR: begin
        rdVal = actTot;
        rdLen = 3'h3;
      end
      ADDR_ACTIVE_LINECYC: begin
        rdVal = actLine;
        rdLen = 3'h3;
      end
      ADDR_REACTIVE_ACC, ADDR_REACTIVE_ACC_CLR: begin
        rdVal = HAS_REACTIVE ? reTot : '0;
        rdLen = 3'h3;
      end
      ADDR_REACTIVE_LINECYC: begin
        rdVal = HAS_REACTIVE ? reLine : '0;
        rdLen = 3'h3;
      end
      ADDR_APPARENT_ACC, ADDR_APPARENT_ACC_CLR: begin
        rdVal = apTot;
        rdLen = 3'h3;
      end
      ADDR_APPARENT_LINECYC: begin
        rdVal = apLine;
        rdLen = 3'h3;
      end
      ADDR_LINE_PERIOD_FREQ: begin
        rdVal = {8'h00, cfg2_r[CFG2_FREQ_SEL_BIT] ? freqVal : periodVal};
        rdLen = 3'h2;
      end
      ADDR_CONFIG_ONE: rdVal = {16'h0000, cfg1_r};
      ADDR_CONFIG_TWO: rdVal = {16'h0000, cfg2_r};
      ADDR_WAVEFORM_SELECT: rdVal = {16'h0000, wave_r};
      ADDR_NO_LOAD_THRESHOLD: rdVal = {16'h0000, noLoad_r};
      ADDR_ACCUMULATION_CONFIG: rdVal = {16'h0000, accCfg_r};
      ADDR_PHASE_CALIBRATION: rdVal = {16'h0000, phase_calibration_r};
      ADDR_ZERO_CROSS_TIMEOUT: begin
        rdVal = {12'h000, zero_cross_timeout_r};
        rdLen = 3'h2;
      end
      ADDR_LINE_CYCLE_COUNT: begin
        rdVal = {8'h00, lineCnt_r};
        rdLen = 3'h2;
      end
      ADDR_SAG_CYCLE_COUNT: rdVal = {16'h0000, sag_cycle_count_r};
      ADDR_SAG_LEVEL: begin
        rdVal = {8'h00, sag_level_r};
        rdLen = 3'h2;
      end
      ADDR_CURRENT_PEAK_THRESHOLD: begin
        rdVal = {8'h00, iThr_r};
        rdLen = 3'h2;
      end
      ADDR_VOLTAGE_PEAK_THRESHOLD: begin
        rdVal = {8'h00, vThr_r};
        rdLen = 3'h2;
      end
      ADDR_CURRENT_PEAK, ADDR_CURRENT_PEAK_CLR: begin
        rdVal = current_peak_r;
        rdLen = 3'h3;
      end
      ADDR_VOLTAGE_PEAK, ADDR_VOLTAGE_PEAK_CLR: begin
        rdVal = voltage_peak_r;
        rdLen = 3'h3;
      end
      ADDR_PGA_GAIN: rdVal = {16'h0000, gain_r};
      default: rdVal = 24'h000000;
    endcase
  end

  // ************************************************
  // pointer, data bytes and writable registers
  // ************************************************
  always_comb begin
    ptr_nxt = access ? ptrWrData : ptr_r;
    dLow_nxt = dataWrEn[0] ? dataWrData : dLow_r;
    dMid_nxt = dataWrEn[1] ? dataWrData : dMid_r;
    dHigh_nxt = dataWrEn[2] ? dataWrData : dHigh_r;
    if (isRead) begin
      dLow_nxt = rdVal[7:0];
      dMid_nxt = (rdLen > 3'h1) ? rdVal[15:8] : 8'h00;
      dHigh_nxt = (rdLen > 3'h2) ? rdVal[23:16] : 8'h00;
    end
    cfg1_nxt = cfg1_r;
    cfg2_nxt = cfg2_r;
    wave_nxt = wave_r;
    noLoad_nxt = noLoad_r;
    accCfg_nxt = accCfg_r;
    phase_calibration_nxt = phase_calibration_r;
    zero_cross_timeout_nxt = zero_cross_timeout_r;
    lineCnt_nxt = lineCnt_r;
    sag_cycle_count_nxt = sag_cycle_count_r;
    sag_level_nxt = sag_level_r;
    iThr_nxt = iThr_r;
    vThr_nxt = vThr_r;
    gain_nxt = gain_r;
    if (isWrite) begin
      case (addr)
        ADDR_CONFIG_ONE: cfg1_nxt = dLow_r;
        ADDR_CONFIG_TWO: cfg2_nxt = dLow_r;
        ADDR_WAVEFORM_SELECT: wave_nxt = dLow_r;
        ADDR_NO_LOAD_THRESHOLD: noLoad_nxt = dLow_r;
        ADDR_ACCUMULATION_CONFIG: accCfg_nxt = dLow_r;
        ADDR_PHASE_CALIBRATION: phase_calibration_nxt = dLow_r;
        ADDR_ZERO_CROSS_TIMEOUT: zero_cross_timeout_nxt = {dMid_r[3:0], dLow_r};
        ADDR_LINE_CYCLE_COUNT: lineCnt_nxt = {dMid_r, dLow_r};
        ADDR_SAG_CYCLE_COUNT: sag_cycle_count_nxt = dLow_r;
        ADDR_SAG_LEVEL: sag_level_nxt = {dMid_r, dLow_r};
        ADDR_CURRENT_PEAK_THRESHOLD: iThr_nxt = {dMid_r, dLow_r};
        ADDR_VOLTAGE_PEAK_THRESHOLD: vThr_nxt = {dMid_r, dLow_r};
        ADDR_PGA_GAIN: gain_nxt = dLow_r;
        default: gain_nxt = gain_r;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ptr_r <= RST_BYTE_ZERO;
      dLow_r <= RST_BYTE_ZERO;
      dMid_r <= RST_BYTE_ZERO;
      dHigh_r <= RST_BYTE_ZERO;
      cfg1_r <= RST_CONFIG_ONE;
      cfg2_r <= RST_CONFIG_TWO;
      wave_r <= RST_BYTE_ZERO;
      noLoad_r <= RST_BYTE_ZERO;
      accCfg_r <= RST_BYTE_ZERO;
      phase_calibration_r <= RST_PHASE_CALIBRATION;
      zero_cross_timeout_r <= RST_ZERO_CROSS_TIMEOUT;
      lineCnt_r <= RST_LINE_CYCLE_COUNT;
      sag_cycle_count_r <= RST_SAG_CYCLE_COUNT;
      sag_level_r <= RST_HALF_ZERO;
      iThr_r <= RST_PEAK_THRESHOLD;
      vThr_r <= RST_PEAK_THRESHOLD;
      gain_r <= RST_BYTE_ZERO;
      halfCnt_r <= RST_HALF_ZERO;
      current_peak_r <= '0;
      voltage_peak_r <= '0;
      lineEnd_r <= 1'b0;
      iEvt_r <= 1'b0;
      vEvt_r <= 1'b0;
    end else begin
      ptr_r <= ptr_nxt;
      dLow_r <= dLow_nxt;
      dMid_r <= dMid_nxt;
      dHigh_r <= dHigh_nxt;
      cfg1_r <= cfg1_nxt;
      cfg2_r <= cfg2_nxt;
      wave_r <= wave_nxt;
      noLoad_r <= noLoad_nxt;
      accCfg_r <= accCfg_nxt;
      phase_calibration_r <= phase_calibration_nxt;
      zero_cross_timeout_r <= zero_cross_timeout_nxt;
      lineCnt_r <= lineCnt_nxt;
      sag_cycle_count_r <= sag_cycle_count_nxt;
      sag_level_r <= sag_level_nxt;
      iThr_r <= iThr_nxt;
      vThr_r <= vThr_nxt;
      gain_r <= gain_nxt;
      halfCnt_r <= halfCnt_nxt;
      current_peak_r <= current_peak_nxt;
      voltage_peak_r <= voltage_peak_nxt;
      lineEnd_r <= lineEnd_nxt;
      iEvt_r <= iEvt_nxt;
      vEvt_r <= vEvt_nxt;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign ptrByte = ptr_r;
  assign dataLow = dLow_r;
  assign dataMid = dMid_r;
  assign dataHigh = dHigh_r;
  assign configOne = cfg1_r;
  assign configTwo = cfg2_r;
  assign waveformSelect = wave_r;
  assign noLoadThreshold = noLoad_r;
  assign accumulationConfig = accCfg_r;
  assign phaseCalibration = phase_calibration_r;
  assign zeroCrossTimeout = zero_cross_timeout_r;
  assign sagCycleCount = sag_cycle_count_r;
  assign sagLevel = sag_level_r;
  assign pgaGain = gain_r;
  assign lineCycleDone = lineEnd_r;
  assign currentPeakEvent = iEvt_r;
  assign voltagePeakEvent = vEvt_r;
endmodule // mtr_regbank
`default_nettype wire

// >>> core/mtr_pkg.sv
// constants for the metering internal register bank
package mtr_pkg;

  // ************************************************
  // widths
  // ************************************************
  localparam int ADDR_W = 7;
  localparam int BYTE_W = 8;
  localparam int ENERGY_W = 24;
  localparam int PEAK_W = 24;
  localparam int HALF_W = 16;
  localparam int TOUT_W = 12;
  localparam int THR_LSB = 8;
  localparam int PTR_WR_BIT = 7;

  // ************************************************
  // internal register addresses
  // ************************************************
  localparam logic [6:0] ADDR_ACTIVE_ACC = 7'h01;
  localparam logic [6:0] ADDR_ACTIVE_ACC_CLR = 7'h02;
  localparam logic [6:0] ADDR_ACTIVE_LINECYC = 7'h03;
  localparam logic [6:0] ADDR_REACTIVE_ACC = 7'h04;
  localparam logic [6:0] ADDR_REACTIVE_ACC_CLR = 7'h05;
  localparam logic [6:0] ADDR_REACTIVE_LINECYC = 7'h06;
  localparam logic [6:0] ADDR_APPARENT_ACC = 7'h07;
  localparam logic [6:0] ADDR_APPARENT_ACC_CLR = 7'h08;
  localparam logic [6:0] ADDR_APPARENT_LINECYC = 7'h09;
  localparam logic [6:0] ADDR_LINE_PERIOD_FREQ = 7'h0a;
  localparam logic [6:0] ADDR_CONFIG_ONE = 7'h0b;
  localparam logic [6:0] ADDR_CONFIG_TWO = 7'h0c;
  localparam logic [6:0] ADDR_WAVEFORM_SELECT = 7'h0d;
  localparam logic [6:0] ADDR_NO_LOAD_THRESHOLD = 7'h0e;
  localparam logic [6:0] ADDR_ACCUMULATION_CONFIG = 7'h0f;
  localparam logic [6:0] ADDR_PHASE_CALIBRATION = 7'h10;
  localparam logic [6:0] ADDR_ZERO_CROSS_TIMEOUT = 7'h11;
  localparam logic [6:0] ADDR_LINE_CYCLE_COUNT = 7'h12;
  localparam logic [6:0] ADDR_SAG_CYCLE_COUNT = 7'h13;
  localparam logic [6:0] ADDR_SAG_LEVEL = 7'h14;
  localparam logic [6:0] ADDR_CURRENT_PEAK_THRESHOLD = 7'h15;
  localparam logic [6:0] ADDR_VOLTAGE_PEAK_THRESHOLD = 7'h16;
  localparam logic [6:0] ADDR_CURRENT_PEAK = 7'h17;
  localparam logic [6:0] ADDR_CURRENT_PEAK_CLR = 7'h18;
  localparam logic [6:0] ADDR_VOLTAGE_PEAK = 7'h19;
  localparam logic [6:0] ADDR_VOLTAGE_PEAK_CLR = 7'h1a;
  localparam logic [6:0] ADDR_PGA_GAIN = 7'h1b;

  // ************************************************
  // reset values
  // ************************************************
  localparam logic [7:0] RST_CONFIG_ONE = 8'h06;
  localparam logic [7:0] RST_CONFIG_TWO = 8'h40;
  localparam logic [7:0] RST_PHASE_CALIBRATION = 8'h40;
  localparam logic [11:0] RST_ZERO_CROSS_TIMEOUT = 12'hfff;
  localparam logic [15:0] RST_LINE_CYCLE_COUNT = 16'hffff;
  localparam logic [7:0] RST_SAG_CYCLE_COUNT = 8'hff;
  localparam logic [15:0] RST_PEAK_THRESHOLD = 16'hffff;
  localparam logic [7:0] RST_BYTE_ZERO = 8'h00;
  localparam logic [15:0] RST_HALF_ZERO = 16'h0000;

  // ************************************************
  // field positions in config_two
  // ************************************************
  localparam int CFG2_RMS_SEL_BIT = 0;
  localparam int CFG2_FREQ_SEL_BIT = 1;

endpackage

// >>> core/mtr_energy_chan.sv
// one energy accumulator with free-running and line-cycle totals
`timescale 1ns/1ps
`default_nettype none
module mtr_energy_chan #(
  parameter int W = 24
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // accumulation
  input wire logic addEn,
  input wire logic [W-1:0] delta,
  input wire logic clrReq,
  input wire logic lineEnd,
  // results
  output logic [W-1:0] total,
  output logic [W-1:0] lineTotal
);
  logic [W-1:0] total_r, total_nxt;
  logic [W-1:0] lineAcc_r, lineAcc_nxt;
  logic [W-1:0] lineTotal_r, lineTotal_nxt;
  logic [W-1:0] add;

  always_comb begin
    add = addEn ? delta : '0;
    // increment arriving with the clear survives it
    total_nxt = clrReq ? add : total_r + add;
    lineAcc_nxt = lineEnd ? '0 : lineAcc_r + add;
    lineTotal_nxt = lineEnd ? lineAcc_r + add : lineTotal_r;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      total_r <= '0;
      lineAcc_r <= '0;
      lineTotal_r <= '0;
    end else begin
      total_r <= total_nxt;
      lineAcc_r <= lineAcc_nxt;
      lineTotal_r <= lineTotal_nxt;
    end
  end

  assign total = total_r;
  assign lineTotal = lineTotal_r;
endmodule // mtr_energy_chan
`default_nettype wire

// >>> bench/mtr_regbank_props.sv
// assertion checker for the metering register bank
`timescale 1ns/1ps
`default_nettype none
module mtr_regbank_props (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // processor side
  input wire logic ptrWrEn,
  input wire logic [7:0] ptrWrData,
  input wire logic [2:0] dataWrEn,
  input wire logic [7:0] ptrByte,
  input wire logic [7:0] dataLow,
  input wire logic [7:0] dataMid,
  input wire logic [7:0] dataHigh,
  // datapath and settings
  input wire logic halfCycle,
  input wire logic [15:0] periodVal,
  input wire logic [15:0] freqVal,
  input wire logic [7:0] configOne,
  input wire logic [7:0] configTwo,
  input wire logic [11:0] zeroCrossTimeout,
  input wire logic [15:0] sagLevel,
  input wire logic [7:0] pgaGain,
  input wire logic lineCycleDone
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ********
  // properties
  // ********
  AST_PTR: assert property (ptrWrEn |=> ptrByte == $past(ptrWrData))
    else $error("pointer byte not taken");
  AST_RST: assert property ($rose(rstn) |-> configOne == 8'h06 && configTwo == 8'h40
    && zeroCrossTimeout == 12'hfff && sagLevel == 16'h0000) else $error("bad reset value");
  AST_RD_CFG: assert property (ptrWrEn && ptrWrData == 8'h0b |=>
    dataLow == $past(configOne)) else $error("config read wrong");
  AST_WR_CFG: assert property (ptrWrEn && ptrWrData == 8'h8c |=>
    configTwo == $past(dataLow)) else $error("config write wrong");
  AST_WR_ZX: assert property (ptrWrEn && ptrWrData == 8'h91 |=>
    zeroCrossTimeout == $past({dataMid[3:0], dataLow})) else $error("timeout write wrong");
  AST_WR_SAG: assert property (ptrWrEn && ptrWrData == 8'h94 |=>
    sagLevel == $past({dataMid, dataLow})) else $error("sag level write wrong");
  AST_WR_GAIN: assert property (ptrWrEn && ptrWrData == 8'h9b |=>
    pgaGain == $past(dataLow)) else $error("gain write wrong");
  AST_ONEBYTE: assert property (ptrWrEn && ptrWrData inside {8'h0b, 8'h0c, 8'h0d,
    8'h0e, 8'h0f, 8'h10, 8'h13, 8'h1b} |=> dataMid == 8'h00 && dataHigh == 8'h00)
    else $error("upper bytes not zero");
  AST_PERIOD: assert property (ptrWrEn && ptrWrData == 8'h0a |=>
    {dataHigh, dataMid, dataLow} == {8'h00, (($past(configTwo) & 8'h02) != 8'h00) ?
    $past(freqVal) : $past(periodVal)}) else $error("period read wrong");
  AST_LINE: assert property (lineCycleDone |-> $past(halfCycle))
    else $error("line done without half cycle");
  AST_HOLD: assert property (!ptrWrEn && dataWrEn == 3'h0 |=>
    $stable({dataHigh, dataMid, dataLow})) else $error("data bytes moved");
endmodule // mtr_regbank_props
bind mtr_regbank mtr_regbank_props u_props (.ref_clk, .rstn, .ptrWrEn, .ptrWrData,
  .dataWrEn, .ptrByte, .dataLow, .dataMid, .dataHigh, .halfCycle, .periodVal, .freqVal,
  .configOne, .configTwo, .zeroCrossTimeout, .sagLevel, .pgaGain, .lineCycleDone);
`default_nettype wire

// >>> bench/mtr_cpu_model.sv
// processor model driving the pointer and data bytes
`timescale 1ns/1ps
`default_nettype none
module mtr_cpu_model (
  // clock
  input wire logic ref_clk,
  // pointer and data byte writes
  output logic ptrWrEn,
  output logic [7:0] ptrWrData,
  output logic [2:0] dataWrEn,
  output logic [7:0] dataWrData
);
  initial begin
    ptrWrEn = 1'b0;
    ptrWrData = 8'h00;
    dataWrEn = 3'h0;
    dataWrData = 8'h00;
  end
  task automatic access(input logic wr, input logic [6:0] a, input logic [23:0] v);
    if (wr) begin
      for (int i = 0; i < 3; i++) begin
        @(negedge ref_clk);
        dataWrEn = 3'(1 << i);
        dataWrData = v[8 * i +: 8];
      end
      @(negedge ref_clk);
      dataWrEn = 3'h0;
      dataWrData = ~dataWrData;
    end
    @(negedge ref_clk);
    ptrWrEn = 1'b1;
    ptrWrData = {wr, a};
    @(negedge ref_clk);
    ptrWrEn = 1'b0;
    ptrWrData = ~ptrWrData;
    repeat (2) @(negedge ref_clk);
  endtask
endmodule // mtr_cpu_model
`default_nettype wire

// >>> bench/mtr_regbank_tb.sv
// self-checking bench for the metering register bank
`timescale 1ns/1ps
`default_nettype none
module mtr_regbank_tb;
  import mtr_pkg::*;
  logic ref_clk;
  logic rstn;
  logic ptrWrEn;
  logic [7:0] ptrWrData;
  logic [2:0] dataWrEn;
  logic [7:0] dataWrData;
  logic [7:0] dataLow;
  logic [7:0] dataMid;
  logic [7:0] dataHigh;
  logic [3:0] vld;
  logic [23:0] dl;
  logic halfCycle;
  logic [15:0] periodVal;
  logic [15:0] freqVal;
  logic sampleValid;
  logic [23:0] smp [2];
  logic [23:0] pk [2];
  logic [23:0] s;
  logic [23:0] e;
  logic [23:0] expQ [$];
  logic [6:0] adrQ [$];
  logic [6:0] adr;
  logic rdPend;
  logic smpPend;
  logic currentPeakEvent;
  logic voltagePeakEvent;
  logic [1:0] ev;
  logic [1:0] evQ [$];
  logic [15:0] thr [2];
  int fails;
  int testsRun;
  mtr_cpu_model cpu (.ref_clk(ref_clk), .ptrWrEn(ptrWrEn), .ptrWrData(ptrWrData),
    .dataWrEn(dataWrEn), .dataWrData(dataWrData));
  mtr_regbank uut (
    .ref_clk(ref_clk), .rstn(rstn), .ptrWrEn(ptrWrEn), .ptrWrData(ptrWrData),
    .dataWrEn(dataWrEn), .dataWrData(dataWrData), .ptrByte(),
    .dataLow(dataLow), .dataMid(dataMid), .dataHigh(dataHigh),
    .activeValid(vld[0]), .activeDelta(dl), .reactiveValid(vld[1]), .reactiveDelta(dl),
    .apparentValid(vld[2]), .apparentDelta(dl), .irmsValid(vld[3]), .irmsDelta(dl),
    .halfCycle(halfCycle), .periodVal(periodVal), .freqVal(freqVal),
    .sampleValid(sampleValid), .currentSample(smp[0]), .voltageSample(smp[1]),
    .configOne(), .configTwo(), .waveformSelect(), .noLoadThreshold(),
    .accumulationConfig(), .phaseCalibration(), .zeroCrossTimeout(), .sagCycleCount(),
    .sagLevel(), .pgaGain(), .lineCycleDone(), .currentPeakEvent(currentPeakEvent),
    .voltagePeakEvent(voltagePeakEvent));
  // ********
  // helpers
  // ********
  function automatic logic [23:0] rstv(input logic [6:0] a);
    case (a)
      7'h0b: return 24'h000006;
      7'h0c, 7'h10: return 24'h000040;
      7'h11: return 24'h000fff;
      7'h12, 7'h15, 7'h16: return 24'h00ffff;
      7'h13: return 24'h0000ff;
      default: return 24'h000000;
    endcase
  endfunction
  function automatic logic [23:0] wm(input logic [6:0] a);
    case (a)
      7'h11: return 24'h000fff;
      7'h12, 7'h14, 7'h15, 7'h16: return 24'h00ffff;
      default: return 24'h0000ff;
    endcase
  endfunction
  task automatic rd(input logic [6:0] a, input logic [23:0] x);
    expQ.push_back(x);
    adrQ.push_back(a);
    cpu.access(1'b0, a, 24'h000000);
  endtask
  task automatic wr(input logic [6:0] a, input logic [23:0] x);
    cpu.access(1'b1, a, x);
  endtask
  task automatic pulse(input logic [3:0] m, input logic h);
    @(negedge ref_clk);
    dl = 24'($urandom);
    vld = m;
    halfCycle = h;
    @(negedge ref_clk);
    vld = 4'h0;
    halfCycle = 1'b0;
  endtask
  task automatic sample();
    @(negedge ref_clk);
    smp[0] = 24'($urandom);
    smp[1] = 24'($urandom);
    evQ.push_back({smp[1][23:8] > thr[1], smp[0][23:8] > thr[0]});
    sampleValid = 1'b1;
    @(negedge ref_clk);
    sampleValid = 1'b0;
    for (int i = 0; i < 2; i++)
      if (smp[i] > pk[i]) pk[i] = smp[i];
  endtask
  task automatic endSim();
    if (fails == 0 && testsRun > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ********
  // clock, monitor, watchdog
  // ********
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (rdPend) begin
      e = expQ.pop_front();
      adr = adrQ.pop_front();
      testsRun++;
      if ({dataHigh, dataMid, dataLow} !== e) begin
        fails++;
        $display("FAIL read %h exp %h got %h", adr, e, {dataHigh, dataMid, dataLow});
      end
    end
    if (smpPend) begin
      ev = evQ.pop_front();
      testsRun++;
      if ({voltagePeakEvent, currentPeakEvent} !== ev) begin
        fails++;
        $display("FAIL peak event exp %h got %h", ev, {voltagePeakEvent, currentPeakEvent});
      end
    end
    rdPend <= rstn && ptrWrEn && !ptrWrData[7];
    smpPend <= rstn && sampleValid;
  end
  initial begin
    // traffic needs about 500 cycles
    repeat (10000) @(posedge ref_clk);
    fails++;
    endSim();
  end
  // ********
  // main sequence
  // ********
  initial begin
    rstn = 1'b0;
    rdPend = 1'b0;
    smpPend = 1'b0;
    thr[0] = 16'hffff;
    thr[1] = 16'hffff;
    vld = 4'h0;
    dl = 24'h000000;
    halfCycle = 1'b0;
    periodVal = 16'h0000;
    freqVal = 16'h0000;
    sampleValid = 1'b0;
    smp[0] = 24'h000000;
    smp[1] = 24'h000000;
    pk[0] = 24'h000000;
    pk[1] = 24'h000000;
    fails = 0;
    testsRun = 0;
    repeat (8) @(negedge ref_clk);
    rstn = 1'b1;
    void'($urandom(32'h2234));
    periodVal = 16'($urandom);
    freqVal = 16'($urandom);
    // period register shows the live datapath value, not a stored reset value
    for (int a = 0; a < 29; a++) rd(7'(a), (a == 10) ? {8'h00, periodVal} : rstv(7'(a)));
    // line window closes with an increment in the same cycle
    wr(7'h12, 24'h000002);
    pulse(4'h7, 1'b0);
    s = dl;
    pulse(4'h0, 1'b1);
    pulse(4'h7, 1'b1);
    s += dl;
    for (int b = 1; b < 8; b += 3) begin
      rd(7'(b + 2), s);
      rd(7'(b), s);
      rd(7'(b + 1), s);
      rd(7'(b), 24'h000000);
      wr(7'(b), 24'($urandom));
      rd(7'(b), 24'h000000);
    end
    wr(7'h0c, 24'h000001);
    pulse(4'h8, 1'b0);
    rd(7'h08, dl);
    rd(7'h02, 24'h000000);
    wr(7'h0c, 24'h000002);
    pulse(4'h8, 1'b0);
    rd(7'h07, 24'h000000);
    rd(7'h0a, {8'h00, freqVal});
    wr(7'h0c, 24'h000000);
    rd(7'h0a, {8'h00, periodVal});
    repeat (3) sample();
    for (int p = 0; p < 2; p++) begin
      rd(7'(23 + 2 * p), pk[p]);
      rd(7'(24 + 2 * p), pk[p]);
      wr(7'(23 + 2 * p), 24'($urandom));
      rd(7'(23 + 2 * p), 24'h000000);
    end
    for (int a = 11; a < 28; a++) begin
      if (a > 22 && a < 27) continue;
      s = 24'($urandom);
      wr(7'(a), s);
      rd(7'(a), s & wm(7'(a)));
    end
    thr[0] = 16'h0080;
    thr[1] = 16'h8000;
    wr(7'h15, {8'h00, thr[0]});
    wr(7'h16, {8'h00, thr[1]});
    repeat (3) sample();
    wr(7'h7f, 24'($urandom));
    rd(7'h7f, 24'h000000);
    endSim();
  end
endmodule // mtr_regbank_tb
`default_nettype wire
